/* hdl/io_clock_power_config.sv */
`timescale 1ns/1ps
`include "io_clock_power_config_defines.svh"

// Overview of operation
// RL1 - address line 15 driven low on external access when force and write enable set
// RL2 - upper bit-I/O on pins replaces the vector outputs when enabled
// RL3 - external program memory writes pass only while write enable is set
// RL4 - second serial port and low bit-I/O take shared pins from host port
// RL5 - loopback feeds each serial data output into its own serial data input
// RL6 - four delay bits add delay to ROM, upper RAM, I/O, lower RAM
// RL7 - three-bit clock output select; codes 110 and 111 reserved
// RL8 - clock output phase restarts at reset release
// RL9 - slow select makes free and wait-stated outputs follow the ring oscillator
// RL10 - wait-stated clock tracks instruction cycle, stretched, one cycle per sequenced access
// RL11 - sequenced wait-stated clock makes two stretched cycles per sequenced access
// RL12 - crystal-off bit powers down the clock input circuit
// RL13 - slow select moves the internal clock onto the ring oscillator
// RL14 - clock-stop bit halts the processor clock until cleared
// RL15 - with wake enable, interrupt 0 clears clock-stop
// RL16 - with wake enable, interrupt 1 clears clock-stop
// RL17 - peripheral disable bits switch off serial ports, host port, timer, coprocessor
// RL18 - software writes zeros into reserved power control bits
// RL19 - wait-state register loads all ones if mode pin high and interrupt 1 low
// RL20 - wait-state register holds four 4-bit counts per external segment
// RL21 - both configuration registers clear on reset, writes act next cycle
module io_clock_power_config (
   input  wire logic                              ref_clk,
   input  wire logic                              rst_n,
   input  wire logic                              clkEn,
   input  wire io_clock_power_config_pkg::avmm_req_s avmReq,
   output logic [31:0]                            avmReadData,
   output logic                                   avmWaitRequest,
   input  wire io_clock_power_config_pkg::pin_in_s  pinIn,
   input  wire io_clock_power_config_pkg::core_in_s coreIn,
   output io_clock_power_config_pkg::pin_out_s      pinOut,
   output io_clock_power_config_pkg::core_out_s     coreOut
);
   import io_clock_power_config_pkg::*;

   state_s      s_q;
   state_s      s_d;
   logic        busReq;
   clkout_sel_e clkSel;
   logic [3:0]  segWait;
   logic [5:0]  halfLen;
   logic        tick;
   logic        wake;
   logic [15:0] ioWord;
   logic [15:0] pcWord;
   logic [15:0] mwWord;
   logic [15:0] ioNext;
   logic [15:0] pcNext;
   logic [15:0] mwNext;
   logic [15:0] wordSel;
   logic [31:0] statusWord;

   // low two byte lanes only
   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [31:0] wd,
      input logic [3:0]  be
   );
      logic [15:0] res;
      res = old;
      if (be[0]) begin
         res[7:0] = wd[7:0];
      end
      if (be[1]) begin
         res[15:8] = wd[15:8];
      end
      return res;
   endfunction

   function automatic logic [3:0] waitOf(
      input mem_wait_s mw,
      input segment_e  seg
   );
      logic [3:0] res;
      res = 4'h0;
      case (seg)
         SEG_EXT_ROM:   res = mw.extRomWait;
         SEG_UPPER_RAM: res = mw.upperRamWait;
         SEG_IO:        res = mw.ioWait;
         SEG_LOWER_RAM: res = mw.lowerRamWait;
         default:       res = 4'h0;
      endcase
      return res;
   endfunction

   assign busReq = avmReq.read | avmReq.write;
   // answer is held back while the clock enable freezes the state
   assign avmWaitRequest = busReq & ~(s_q.ack & clkEn);
   assign avmReadData = s_q.rdata;
   assign pinOut = s_q.pins;
   assign coreOut = s_q.core;

   assign ioWord = s_q.io;
   assign pcWord = s_q.pc;
   assign mwWord = s_q.mw;
   assign statusWord = {24'h000000,
                        s_q.strapOnes,
                        s_q.strap == STRAP_DONE,
                        ~s_q.pc.clockStop,
                        s_q.pc.slowClockSelect,
                        s_q.sync2.irq1,
                        s_q.sync2.irq0,
                        s_q.wsHigh,
                        s_q.pins.clockOutput};

   always_comb begin
      wordSel = 16'h0000;
      case ({avmReq.address[3:2], 2'b00})
         `IOCFG_OFFSET:   wordSel = ioWord;
         `PWRCTL_OFFSET:  wordSel = pcWord;
         `MEMWAIT_OFFSET: wordSel = mwWord;
         default:              wordSel = 16'h0000;
      endcase
   end

   // reserved bits are never stored, whatever software writes [RL18]
   assign ioNext = merge16(ioWord, avmReq.writedata, avmReq.byteenable) & `IOCFG_MASK;
   assign pcNext = merge16(pcWord, avmReq.writedata, avmReq.byteenable) & `PWRCTL_MASK;
   assign mwNext = merge16(mwWord, avmReq.writedata, avmReq.byteenable);

   assign clkSel = clkout_sel_e'({s_q.io.clkoutSelHi, s_q.io.clkoutSelLo}); // [RL7]
   assign segWait = coreIn.extAccess ? waitOf(s_q.mw, coreIn.accessSegment) : 4'h0; // [RL10]
   // ring oscillator edges pace the generators under slow clock [RL9]
   assign tick = s_q.pc.slowClockSelect ? (s_q.sync2.ringOsc & ~s_q.ringDly) : 1'b1;
   assign wake = (s_q.pc.firstIrqWakeEn & s_q.sync2.irq0) // [RL15]
               | (s_q.pc.secondIrqWakeEn & s_q.sync2.irq1); // [RL16]

   always_comb begin
      halfLen = {2'b00, segWait} + 6'h01;
      // plain wait-stated clock spans both words of a sequenced access [RL10]
      if (coreIn.seqAccess && clkSel == CLK_WAIT) begin
         halfLen = {halfLen[4:0], 1'b0};
      end
   end

   always_comb begin
      s_d = s_q;

      s_d.sync1.extMode = pinIn.extModePin;
      s_d.sync1.irq0 = pinIn.irq0Pin;
      s_d.sync1.irq1 = pinIn.irq1Pin;
      s_d.sync1.inClk = pinIn.inputClockPin;
      s_d.sync1.ringOsc = pinIn.ringOscPin;
      s_d.sync1.serOne = pinIn.serialOneDataPin;
      s_d.sync1.serTwo = pinIn.serialTwoDataPin;
      s_d.sync1.upper = pinIn.upperPins;
      s_d.sync1.shared = pinIn.sharedPins;
      s_d.sync2 = s_q.sync1;
      s_d.ringDly = s_q.sync2.ringOsc;

      // register bus: one wait cycle, then answer
      s_d.ack = busReq & ~s_q.ack;
      if (avmReq.read && !s_q.ack) begin
         s_d.rdata = ({avmReq.address[3:2], 2'b00} == `STATUS_OFFSET) ? statusWord : {16'h0000, wordSel};
      end
      if (avmReq.write && s_q.ack) begin
         case ({avmReq.address[3:2], 2'b00})
            `IOCFG_OFFSET:   s_d.io = io_config_s'(ioNext); // [RL21]
            `PWRCTL_OFFSET:  s_d.pc = power_control_s'(pcNext); // [RL21]
            `MEMWAIT_OFFSET: s_d.mw = mem_wait_s'(mwNext); // [RL20]
            default:              s_d.rdata = s_q.rdata;
         endcase
      end

      // wake runs after the write so an interrupt is never lost
      if (wake) begin
         s_d.pc.clockStop = 1'b0; // [RL15] [RL16]
      end

      // strap sampled only once the synchronisers hold real pin levels
      case (s_q.strap)
         STRAP_SYNC1: s_d.strap = STRAP_SYNC2;
         STRAP_SYNC2: s_d.strap = STRAP_LOAD;
         STRAP_LOAD: begin
            s_d.strap = STRAP_DONE;
            s_d.strapOnes = s_q.sync2.extMode & ~s_q.sync2.irq1;
            s_d.mw = s_d.strapOnes ? mem_wait_s'(`MEMWAIT_STRAP) : mem_wait_s'(`MEMWAIT_RESET); // [RL19]
         end
         STRAP_DONE:  s_d.strap = STRAP_DONE;
         default:     s_d.strap = STRAP_SYNC1;
      endcase

      // clock generators restart from reset, aligning phase to its release [RL8]
      if (tick) begin
         s_d.freeTog = ~s_q.freeTog;
         if (s_q.wsCnt == 5'h00) begin
            s_d.wsHigh = ~s_q.wsHigh;
            s_d.wsCnt = 5'(halfLen - 6'h01); // [RL10] [RL11]
         end else begin
            s_d.wsCnt = s_q.wsCnt - 5'h01;
         end
      end

      case (clkSel)
         CLK_FREE:     s_d.pins.clockOutput = s_q.freeTog; // [RL9]
         CLK_WAIT:     s_d.pins.clockOutput = s_q.wsHigh; // [RL10]
         CLK_HIGH:     s_d.pins.clockOutput = 1'b1;
         CLK_LOW:      s_d.pins.clockOutput = 1'b0;
         CLK_BUFFERED: s_d.pins.clockOutput = s_q.sync2.inClk;
         CLK_SEQ_WAIT: s_d.pins.clockOutput = s_q.wsHigh; // [RL11]
         default:      s_d.pins.clockOutput = 1'b0;
      endcase

      s_d.pins.addressLine15 = coreIn.addrOut15;
      if (s_q.io.extProgAddrForce && s_q.io.extProgWriteEnable && coreIn.extAccess) begin
         s_d.pins.addressLine15 = 1'b0; // [RL1]
      end
      s_d.pins.progWriteStrobe = coreIn.progWriteReq & s_q.io.extProgWriteEnable; // [RL3]

      if (s_q.io.upperBitioEnable) begin
         s_d.pins.upperPins = coreIn.bitioUpperOut; // [RL2]
         s_d.core.bitioUpperIn = s_q.sync2.upper;
      end else begin
         s_d.pins.upperPins = coreIn.vectorOut;
         s_d.core.bitioUpperIn = 4'h0;
      end

      if (s_q.io.secondSerialEnable) begin
         s_d.pins.sharedPins = {coreIn.serialTwoPinsOut, coreIn.bitioLowOut}; // [RL4]
         s_d.core.serialTwoPinsIn = s_q.sync2.shared[7:4];
         s_d.core.bitioLowIn = s_q.sync2.shared[3:0];
         s_d.core.hostPortIn = 8'h00;
      end else begin
         s_d.pins.sharedPins = coreIn.hostPortOut;
         s_d.core.serialTwoPinsIn = 4'h0;
         s_d.core.bitioLowIn = 4'h0;
         s_d.core.hostPortIn = s_q.sync2.shared;
      end

      // loopback stays inside the chip, the pins are simply ignored
      if (s_q.io.serialLoopback) begin
         s_d.core.serialOneDataIn = coreIn.serialOneDataOut; // [RL5]
         s_d.core.serialTwoDataIn = coreIn.serialTwoDataOut; // [RL5]
      end else begin
         s_d.core.serialOneDataIn = s_q.sync2.serOne;
         s_d.core.serialTwoDataIn = s_q.sync2.serTwo;
      end

      s_d.core.memDelay = s_q.io.memDelayBits; // [RL6]
      s_d.core.activeDelay = coreIn.extAccess & s_q.io.memDelayBits[coreIn.accessSegment]; // [RL6]
      s_d.core.waitStates = s_q.mw; // [RL20]

      s_d.core.serialOneOff = s_q.pc.serialOneDisable; // [RL17]
      s_d.core.serialTwoOff = s_q.pc.serialTwoDisable; // [RL17]
      s_d.core.hostPortOff = s_q.pc.hostPortDisable; // [RL17]
      s_d.core.timerOff = s_q.pc.timerDisable; // [RL17]
      s_d.core.eccOff = s_q.pc.eccCoprocDisable; // [RL17]
      s_d.core.crystalPowerDown = s_q.pc.crystalOff; // [RL12]
      s_d.core.slowClockActive = s_q.pc.slowClockSelect; // [RL13]
      s_d.core.coreClockRun = ~s_q.pc.clockStop; // [RL14]
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.io <= io_config_s'(`IOCFG_RESET); // [RL21]
         s_q.pc <= power_control_s'(`PWRCTL_RESET); // [RL21]
         s_q.mw <= mem_wait_s'(`MEMWAIT_RESET);
         s_q.core.coreClockRun <= 1'b1;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

endmodule

/* shared/io_clock_power_config_defines.svh */
`ifndef IO_CLOCK_POWER_CONFIG_DEFINES_SVH
`define IO_CLOCK_POWER_CONFIG_DEFINES_SVH

// register byte offsets on the register bus
`define IOCFG_OFFSET       4'h0
`define PWRCTL_OFFSET      4'h4
`define MEMWAIT_OFFSET     4'h8
`define STATUS_OFFSET      4'hC

// reset values
`define IOCFG_RESET        16'h0000
`define PWRCTL_RESET       16'h0000
`define MEMWAIT_RESET      16'h0000
`define MEMWAIT_STRAP      16'hFFFF

// implemented bits, reserved bits read as zero
`define IOCFG_MASK         16'h7F8F
`define PWRCTL_MASK        16'hF4F1

// field positions of the I/O configuration register
`define IOCFG_ADDR_FORCE   14
`define IOCFG_CLKSEL_HI    13
`define IOCFG_UPPER_BITIO  12
`define IOCFG_PROG_WE      11
`define IOCFG_SER2_EN      10
`define IOCFG_LOOPBACK     9
`define IOCFG_CLKSEL_LO_HI 8
`define IOCFG_CLKSEL_LO_LO 7
`define IOCFG_DELAY_HI     3
`define IOCFG_DELAY_LO     0

// field positions of the power control register
`define PWRCTL_XTAL_OFF    15
`define PWRCTL_SLOW_CLK    14
`define PWRCTL_CLK_STOP    13
`define PWRCTL_WAKE0_EN    12
`define PWRCTL_WAKE1_EN    10
`define PWRCTL_SER1_DIS    7
`define PWRCTL_SER2_DIS    6
`define PWRCTL_HOST_DIS    5
`define PWRCTL_TIMER_DIS   4
`define PWRCTL_ECC_DIS     0

// status register data width in use
`define STATUS_WIDTH       8

`endif

/* shared/io_clock_power_config_pkg.sv */
package io_clock_power_config_pkg;

   typedef enum logic [2:0] {
      CLK_FREE     = 3'h0,
      CLK_WAIT     = 3'h1,
      CLK_HIGH     = 3'h2,
      CLK_LOW      = 3'h3,
      CLK_BUFFERED = 3'h4,
      CLK_SEQ_WAIT = 3'h5,
      CLK_RSVD6    = 3'h6,
      CLK_RSVD7    = 3'h7
   } clkout_sel_e;

   // index matches the bit of the delay field
   typedef enum logic [1:0] {
      SEG_LOWER_RAM = 2'h0,
      SEG_IO        = 2'h1,
      SEG_UPPER_RAM = 2'h2,
      SEG_EXT_ROM   = 2'h3
   } segment_e;

   typedef enum logic [1:0] {
      STRAP_SYNC1 = 2'h0,
      STRAP_SYNC2 = 2'h1,
      STRAP_LOAD  = 2'h3,
      STRAP_DONE  = 2'h2
   } strap_e;

   typedef struct packed {
      logic       rsvd15;
      logic       extProgAddrForce;
      logic       clkoutSelHi;
      logic       upperBitioEnable;
      logic       extProgWriteEnable;
      logic       secondSerialEnable;
      logic       serialLoopback;
      logic [1:0] clkoutSelLo;
      logic [2:0] rsvd6to4;
      logic [3:0] memDelayBits;
   } io_config_s;

   typedef struct packed {
      logic       crystalOff;
      logic       slowClockSelect;
      logic       clockStop;
      logic       firstIrqWakeEn;
      logic       rsvd11;
      logic       secondIrqWakeEn;
      logic [1:0] rsvd9to8;
      logic       serialOneDisable;
      logic       serialTwoDisable;
      logic       hostPortDisable;
      logic       timerDisable;
      logic [2:0] rsvd3to1;
      logic       eccCoprocDisable;
   } power_control_s;

   typedef struct packed {
      logic [3:0] extRomWait;
      logic [3:0] upperRamWait;
      logic [3:0] ioWait;
      logic [3:0] lowerRamWait;
   } mem_wait_s;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } avmm_req_s;

   typedef struct packed {
      logic       extModePin;
      logic       irq0Pin;
      logic       irq1Pin;
      logic       inputClockPin;
      logic       ringOscPin;
      logic       serialOneDataPin;
      logic       serialTwoDataPin;
      logic [3:0] upperPins;
      logic [7:0] sharedPins;
   } pin_in_s;

   typedef struct packed {
      logic       extAccess;
      segment_e   accessSegment;
      logic       seqAccess;
      logic       progWriteReq;
      logic       addrOut15;
      logic [3:0] bitioUpperOut;
      logic [3:0] vectorOut;
      logic [3:0] bitioLowOut;
      logic [3:0] serialTwoPinsOut;
      logic [7:0] hostPortOut;
      logic       serialOneDataOut;
      logic       serialTwoDataOut;
   } core_in_s;

   typedef struct packed {
      logic       clockOutput;
      logic       addressLine15;
      logic       progWriteStrobe;
      logic [3:0] upperPins;
      logic [7:0] sharedPins;
   } pin_out_s;

   typedef struct packed {
      logic       serialOneDataIn;
      logic       serialTwoDataIn;
      logic [3:0] bitioUpperIn;
      logic [3:0] bitioLowIn;
      logic [3:0] serialTwoPinsIn;
      logic [7:0] hostPortIn;
      logic [3:0] memDelay;
      logic       activeDelay;
      mem_wait_s  waitStates;
      logic       serialOneOff;
      logic       serialTwoOff;
      logic       hostPortOff;
      logic       timerOff;
      logic       eccOff;
      logic       crystalPowerDown;
      logic       slowClockActive;
      logic       coreClockRun;
   } core_out_s;

   typedef struct packed {
      logic       extMode;
      logic       irq0;
      logic       irq1;
      logic       inClk;
      logic       ringOsc;
      logic       serOne;
      logic       serTwo;
      logic [3:0] upper;
      logic [7:0] shared;
   } sync_s;

   typedef struct packed {
      io_config_s     io;
      power_control_s pc;
      mem_wait_s      mw;
      strap_e         strap;
      logic           strapOnes;
      logic           ack;
      logic [31:0]    rdata;
      sync_s          sync1;
      sync_s          sync2;
      logic           ringDly;
      logic           freeTog;
      logic           wsHigh;
      logic [4:0]     wsCnt;
      pin_out_s       pins;
      core_out_s      core;
   } state_s;

endpackage

/* verification/io_clock_power_config_assertions.sv */
`timescale 1ns/1ps
`include "io_clock_power_config_defines.svh"
module io_clock_power_config_assertions (
   input wire logic                                  ref_clk,
   input wire logic                                  rst_n,
   input wire logic                                  clkEn,
   input wire io_clock_power_config_pkg::avmm_req_s  avmReq,
   input wire logic [31:0]                           avmReadData,
   input wire logic                                  avmWaitRequest,
   input wire io_clock_power_config_pkg::pin_in_s    pinIn,
   input wire io_clock_power_config_pkg::core_in_s   coreIn,
   input wire io_clock_power_config_pkg::pin_out_s   pinOut,
   input wire io_clock_power_config_pkg::core_out_s  coreOut
);
   import io_clock_power_config_pkg::*;

   io_config_s     ioQ;
   power_control_s pcQ;
   logic           wrHit;
   logic [2:0]     sel;
   logic           freeRun;

   assign wrHit   = avmReq.write && !avmWaitRequest && clkEn;
   assign sel     = {ioQ.clkoutSelHi, ioQ.clkoutSelLo};
   assign freeRun = (sel == CLK_FREE) && !pcQ.slowClockSelect;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [3:0] be, input logic [31:0] wd);
      return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ioQ <= '0;
         pcQ <= '0;
      end else if (wrHit && avmReq.address[3:2] == 2'h0) begin
         ioQ <= io_config_s'(merge(ioQ, avmReq.byteenable, avmReq.writedata) & `IOCFG_MASK);
      end else if (wrHit && avmReq.address[3:2] == 2'h1) begin
         pcQ <= power_control_s'(merge(pcQ, avmReq.byteenable, avmReq.writedata) & `PWRCTL_MASK);
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_bus_one_wait: assert property ($rose(avmReq.read || avmReq.write) && clkEn |=> !avmWaitRequest || !clkEn)
      else $error("bus answer not after one wait cycle");
   a_rdata_upper: assert property (avmReq.read && !avmWaitRequest |-> avmReadData[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_addr_force: assert property ($past(rst_n) && $past(ioQ.extProgAddrForce && ioQ.extProgWriteEnable && coreIn.extAccess)
      |-> !pinOut.addressLine15)
      else $error("address line 15 not forced low");
   a_prog_write: assert property ($past(rst_n) |-> pinOut.progWriteStrobe == $past(coreIn.progWriteReq && ioQ.extProgWriteEnable))
      else $error("program write strobe disagrees with write enable");
   a_upper_pins: assert property ($past(rst_n)
      |-> pinOut.upperPins == $past(ioQ.upperBitioEnable ? coreIn.bitioUpperOut : coreIn.vectorOut))
      else $error("upper pins carry the wrong source");
   a_loop_back: assert property ($past(rst_n) && $past(ioQ.serialLoopback)
      |-> coreOut.serialOneDataIn == $past(coreIn.serialOneDataOut)
          && coreOut.serialTwoDataIn == $past(coreIn.serialTwoDataOut))
      else $error("serial loopback not applied");
   a_mem_delay: assert property ($past(rst_n) |-> coreOut.memDelay == $past(ioQ.memDelayBits))
      else $error("memory delay bits not passed on");
   a_periph_off: assert property ($past(rst_n) |-> {coreOut.serialOneOff, coreOut.serialTwoOff, coreOut.hostPortOff,
      coreOut.timerOff, coreOut.eccOff} == $past({pcQ.serialOneDisable, pcQ.serialTwoDisable, pcQ.hostPortDisable,
      pcQ.timerDisable, pcQ.eccCoprocDisable}))
      else $error("peripheral disable outputs wrong");
   a_xtal_slow: assert property ($past(rst_n) |-> coreOut.crystalPowerDown == $past(pcQ.crystalOff)
      && coreOut.slowClockActive == $past(pcQ.slowClockSelect))
      else $error("crystal or slow clock output wrong");
   a_clock_high: assert property ($past(rst_n) && $past(sel) == CLK_HIGH
      |-> pinOut.clockOutput)
      else $error("clock output not held high");
   a_clock_low: assert property ($past(rst_n) && $past(sel) inside {CLK_LOW, CLK_RSVD6, CLK_RSVD7}
      |-> !pinOut.clockOutput)
      else $error("clock output not held low");
   a_free_toggle: assert property ($past(rst_n, 2) && $past(freeRun) && $past(freeRun, 2)
      |-> pinOut.clockOutput != $past(pinOut.clockOutput))
      else $error("free clock output not toggling");
   a_wake_first: assert property (!coreOut.coreClockRun && pinIn.irq0Pin && pcQ.firstIrqWakeEn
      |-> ##[1:8] coreOut.coreClockRun)
      else $error("first interrupt did not wake clock");
   a_wake_second: assert property (!coreOut.coreClockRun && pinIn.irq1Pin && pcQ.secondIrqWakeEn
      |-> ##[1:8] coreOut.coreClockRun)
      else $error("second interrupt did not wake clock");
endmodule

bind io_clock_power_config io_clock_power_config_assertions chk_u (
   .ref_clk        (ref_clk),
   .rst_n          (rst_n),
   .clkEn          (clkEn),
   .avmReq         (avmReq),
   .avmReadData    (avmReadData),
   .avmWaitRequest (avmWaitRequest),
   .pinIn          (pinIn),
   .coreIn         (coreIn),
   .pinOut         (pinOut),
   .coreOut        (coreOut)
);

/* verification/tb_top.sv */
`timescale 1ns/1ps
`include "io_clock_power_config_defines.svh"
module tb_top;
   import io_clock_power_config_pkg::*;

   logic        ref_clk;
   logic        rst_n;
   logic        clkEn;
   avmm_req_s   avmReq;
   logic [31:0] avmReadData;
   logic        avmWaitRequest;
   pin_in_s     pinIn;
   core_in_s    coreIn;
   pin_out_s    pinOut;
   core_out_s   coreOut;
   int          n_errors;
   int          n_checks;
   logic [31:0] rd;

   io_clock_power_config dut_u (
      .ref_clk        (ref_clk),
      .rst_n          (rst_n),
      .clkEn          (clkEn),
      .avmReq         (avmReq),
      .avmReadData    (avmReadData),
      .avmWaitRequest (avmWaitRequest),
      .pinIn          (pinIn),
      .coreIn         (coreIn),
      .pinOut         (pinOut),
      .coreOut        (coreOut)
   );

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
      int k = 0;
      @(posedge ref_clk);
      avmReq.read       <= !wr;
      avmReq.write      <= wr;
      avmReq.address    <= a;
      avmReq.byteenable <= 4'hF;
      avmReq.writedata  <= {16'h0000, d};
      do begin
         @(posedge ref_clk);
         k++;
      end while (avmWaitRequest !== 1'b0 && k < 40);
      rd = avmReadData;
      avmReq.read  <= 1'b0;
      avmReq.write <= 1'b0;
      if (k >= 40) begin
         n_errors++;
         report_and_stop();
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic wait_run();
      int k = 0;
      while (coreOut.coreClockRun !== 1'b1 && k < 20) begin
         @(negedge ref_clk);
         k++;
      end
      if (k >= 20) begin
         n_errors++;
         report_and_stop();
      end
   endtask

   task automatic do_reset();
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
   endtask

   task automatic t_regs();
      settle(1);
      check(coreOut.coreClockRun, 1'b1);
      bus(1'b0, `IOCFG_OFFSET, '0);
      check(rd, 32'h0000_0000);
      bus(1'b0, `PWRCTL_OFFSET, '0);
      check(rd, 32'h0000_0000);
      bus(1'b1, `IOCFG_OFFSET, 16'hFFFF);
      bus(1'b0, `IOCFG_OFFSET, '0);
      check(rd, 32'h0000_7F8F);
      bus(1'b1, `MEMWAIT_OFFSET, 16'h4321);
      settle(2);
      check(coreOut.waitStates.extRomWait, 4'h4);
      check(coreOut.waitStates.lowerRamWait, 4'h1);
      bus(1'b1, `IOCFG_OFFSET, '0);
      $display("registers done");
   endtask

   task automatic t_route();
      @(posedge ref_clk);
      coreIn.extAccess        <= 1'b1;
      coreIn.addrOut15        <= 1'b1;
      coreIn.progWriteReq     <= 1'b1;
      coreIn.bitioUpperOut    <= 4'hA;
      coreIn.vectorOut        <= 4'h5;
      coreIn.hostPortOut      <= 8'h3C;
      coreIn.serialOneDataOut <= 1'b1;
      bus(1'b1, `IOCFG_OFFSET, 16'h5E00);
      settle(2);
      check(pinOut.addressLine15, 1'b0);
      check(pinOut.progWriteStrobe, 1'b1);
      check(pinOut.upperPins, 4'hA);
      check(pinOut.sharedPins, 8'h00);
      check({coreOut.serialOneDataIn, coreOut.serialTwoDataIn}, 2'b10);
      bus(1'b1, `IOCFG_OFFSET, 16'h400A);
      settle(2);
      check(pinOut.addressLine15, 1'b1);
      check(pinOut.progWriteStrobe, 1'b0);
      check(pinOut.upperPins, 4'h5);
      check(pinOut.sharedPins, 8'h3C);
      check(coreOut.memDelay, 4'hA);
      check(coreOut.serialOneDataIn, 1'b0);
      @(posedge ref_clk);
      coreIn <= '0;
      bus(1'b1, `IOCFG_OFFSET, '0);
      $display("routing done");
   endtask

   task automatic t_clock();
      logic [2:0] c;
      logic       v;
      @(posedge ref_clk);
      pinIn.inputClockPin <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         bus(1'b1, `IOCFG_OFFSET, {2'b00, c[2], 4'h0, c[1:0], 7'h00});
         settle(4);
         v = pinOut.clockOutput;
         settle(1);
         if (c inside {3'h0, 3'h1, 3'h5}) begin
            check(pinOut.clockOutput, !v);
         end else if (c == 3'h4) begin
            check(pinOut.clockOutput, 1'b1);
         end else begin
            check(pinOut.clockOutput, c == 3'h2);
         end
      end
      bus(1'b1, `IOCFG_OFFSET, '0);
      bus(1'b1, `PWRCTL_OFFSET, 16'h4000);
      settle(4);
      v = pinOut.clockOutput;
      check(coreOut.slowClockActive, 1'b1);
      settle(1);
      check(pinOut.clockOutput, v);
      bus(1'b1, `PWRCTL_OFFSET, '0);
      $display("clock done");
   endtask

   task automatic t_power();
      bus(1'b1, `PWRCTL_OFFSET, 16'hF4F1);
      settle(2);
      check({coreOut.crystalPowerDown, coreOut.slowClockActive, coreOut.coreClockRun}, 3'b110);
      check({coreOut.serialOneOff, coreOut.serialTwoOff, coreOut.hostPortOff, coreOut.timerOff, coreOut.eccOff},
         5'h1F);
      bus(1'b0, `PWRCTL_OFFSET, '0);
      check(rd, 32'h0000_F4F1);
      @(posedge ref_clk);
      pinIn.irq0Pin <= 1'b1;
      wait_run();
      check(coreOut.coreClockRun, 1'b1);
      bus(1'b0, `PWRCTL_OFFSET, '0);
      check(rd, 32'h0000_D4F1);
      pinIn.irq0Pin <= 1'b0;
      bus(1'b1, `PWRCTL_OFFSET, 16'h2400);
      @(posedge ref_clk);
      pinIn.irq0Pin <= 1'b1;
      settle(8);
      check(coreOut.coreClockRun, 1'b0);
      @(posedge ref_clk);
      pinIn.irq1Pin <= 1'b1;
      wait_run();
      check(coreOut.coreClockRun, 1'b1);
      bus(1'b0, `PWRCTL_OFFSET, '0);
      check(rd, 32'h0000_0400);
      pinIn.irq0Pin <= 1'b0;
      pinIn.irq1Pin <= 1'b0;
      bus(1'b1, `PWRCTL_OFFSET, '0);
      $display("power done");
   endtask

   task automatic t_strap();
      bus(1'b1, `IOCFG_OFFSET, 16'h0003);
      bus(1'b1, `PWRCTL_OFFSET, 16'h0010);
      pinIn.extModePin <= 1'b1;
      do_reset();
      settle(6);
      check(coreOut.waitStates, 16'hFFFF);
      bus(1'b0, `MEMWAIT_OFFSET, '0);
      check(rd, 32'h0000_FFFF);
      bus(1'b0, `STATUS_OFFSET, '0);
      check(rd & 32'hFFFF_FFFC, 32'h0000_00E0);
      bus(1'b0, `IOCFG_OFFSET, '0);
      check(rd, 32'h0000_0000);
      bus(1'b0, `PWRCTL_OFFSET, '0);
      check(rd, 32'h0000_0000);
      pinIn.irq1Pin <= 1'b1;
      do_reset();
      settle(6);
      check(coreOut.waitStates, 16'h0000);
      @(posedge ref_clk);
      pinIn <= '0;
      $display("strap done");
   endtask

   initial begin
      rst_n    = 1'b0;
      clkEn    = 1'b1;
      avmReq   = '0;
      pinIn    = '0;
      coreIn   = '0;
      n_errors = 0;
      n_checks = 0;
      do_reset();
      t_regs();
      t_route();
      t_clock();
      t_power();
      t_strap();
      report_and_stop();
   end
endmodule
